/* File: rtl/upi_port.v */
// Transceiver side of the link port: clock, direction, handshakes, straps
`timescale 1ns/1ns
`default_nettype none
`include "ulpi_pin_regs.vh"

// Notes on behaviour
// - interface clock out, signals change on rise
// - eight-bit data bus, bit 7 is MSB
// - straps select reference 13/19.2/26/24 MHz
// - next high marks link byte accepted
// - direction high while transceiver has data
// - direction low when idle, watch commands
// - stop means last byte was previous cycle
// - reset low suspends, all pins released
// - bus-power pin senses and pulses
// - commands and status travel in-band
module upi_port (
  input  wire       clock,
  input  wire       nrst,
  input  wire       chip_reset_n,
  input  wire [1:0] ref_freq_select,
  input  wire       reference_clock_in,
  output reg        interface_clock_out,
  input  wire [7:0] data_in,
  output reg  [7:0] data_out,
  output reg  [7:0] data_oe,
  output reg        dir,
  output reg        nxt,
  input  wire       stp,
  input  wire [7:0] tx_data,
  input  wire       tx_valid,
  output reg        tx_ready,
  output reg  [7:0] rx_data,
  output reg        rx_valid,
  input  wire       rx_ready,
  output reg        rx_last,
  input  wire       vbus_pulse_req,
  input  wire       vbus_in,
  output reg        vbus_out,
  output reg        vbus_oe,
  output reg        vbus_valid,
  output reg        ref_ok,
  output reg  [14:0] ref_khz
);
  localparam ST_OFF  = 3'h0;
  localparam ST_IDLE = 3'h1;
  localparam ST_TAU  = 3'h2;
  localparam ST_SEND = 3'h3;
  localparam ST_TAD  = 3'h4;

  reg  [2:0] st_r;
  reg  [2:0] st_nxt;
  reg  [1:0] rst_s_r;
  reg  [1:0] stp_s_r;
  reg  [1:0] vb_s_r;
  reg  [1:0] rc_s_r;
  reg        rc_d_r;
  reg  [7:0] d_s1_r;
  reg  [7:0] d_s2_r;
  reg        div_r;
  reg        tick_r;
  reg        strap_done_r;
  reg        stp_seen_r;
  reg  [7:0] last_byte_r;
  reg        byte_hold_r;
  reg  [1:0] sel_s1_r;
  reg  [1:0] sel_s2_r;
  reg        idle_old_r;
  wire       link_take;
  wire       run;
  wire       buf_in_ready;
  wire [7:0] buf_out_data;
  wire       buf_out_valid;
  wire       buf_pop;

  // Map a strap code to kHz; called only by strap capture
  function [14:0] ref_khz_of;
    input [1:0] sel;
    begin
      case (sel)
        `UPI_REF_SEL_13M:  ref_khz_of = `UPI_REF_KHZ_13M;
        `UPI_REF_SEL_19M2: ref_khz_of = `UPI_REF_KHZ_19M2;
        `UPI_REF_SEL_26M:  ref_khz_of = `UPI_REF_KHZ_26M;
        default:           ref_khz_of = `UPI_REF_KHZ_24M;
      endcase
    end
  endfunction

  // Pin synchronisers; first stages feed only second stages
  // The data bus goes through the same two stages as the control
  // pins, so a byte and the stop that follows it stay in step.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_s_r <= 2'h0;
      stp_s_r <= 2'h0;
      vb_s_r  <= 2'h0;
      rc_s_r  <= 2'h0;
      rc_d_r  <= 1'b0;
      d_s1_r  <= 8'h00;
      d_s2_r  <= 8'h00;
    end else begin
      rst_s_r <= {rst_s_r[0], chip_reset_n};
      stp_s_r <= {stp_s_r[0], stp};
      vb_s_r  <= {vb_s_r[0], vbus_in};
      rc_s_r  <= {rc_s_r[0], reference_clock_in};
      rc_d_r  <= rc_s_r[1];
      d_s1_r  <= data_in;
      d_s2_r  <= d_s1_r;
    end
  end

  // Strap pins get their own pair of stages. They are read once per
  // run, but a strap tied through a slow pull may still be moving as
  // the part leaves reset, so it is settled like any other pin.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sel_s1_r <= 2'h0;
      sel_s2_r <= 2'h0;
    end else begin
      sel_s1_r <= ref_freq_select;
      sel_s2_r <= sel_s1_r;
    end
  end

  // suspend gate
  // Everything below except the receive buffer waits on this; the suspend pin has two stages,
  // so leaving suspend costs two clocks, and the divider two more, before the first tick.
  assign run = rst_s_r[1];

  // interface clock divider and tick
  // The clock out rises on the very edge at which the tick moves the
  // port signals, so they change with that rise and the link has a
  // whole period to sample them before the next one.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_r               <= 1'b0;
      tick_r              <= 1'b0;
      interface_clock_out <= 1'b0;
    end else begin
      div_r               <= run ? ~div_r : 1'b0;
      tick_r              <= run & div_r;
      interface_clock_out <= run & ~div_r;
    end
  end

  // strap capture after reset release
  // Straps are caught once per run, so a later glitch cannot move the PLL.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      strap_done_r <= 1'b0;
      ref_khz      <= 15'h0000;
      ref_ok       <= 1'b0;
    end else if (!run) begin
      strap_done_r <= 1'b0;
      ref_ok       <= 1'b0;
    end else begin
      if (!strap_done_r) begin
        ref_khz      <= ref_khz_of(sel_s2_r);
        strap_done_r <= 1'b1;
      end
      if (rc_s_r[1] & ~rc_d_r)
        ref_ok <= strap_done_r;
    end
  end

  // Direction state machine
  // Only the transmit side steers it; link bytes are taken in idle,
  // so streams in the two directions never overlap on the bus.
  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_OFF:  st_nxt = ST_IDLE;
      ST_IDLE: if (tx_valid) st_nxt = ST_TAU;
      ST_TAU:  st_nxt = ST_SEND;
      ST_SEND: if (!tx_valid) st_nxt = ST_TAD;
      ST_TAD:  st_nxt = ST_IDLE;
      default: st_nxt = ST_OFF;
    endcase
  end

  // Output word moves on whenever the output is empty or the consumer is taking
  assign buf_pop = rx_ready | ~rx_valid;

  // accept a link byte only when buffer has room
  // A next pulse fills the buffer three clocks later, behind the data
  // stages, so a pulse already out blocks the following one: half the
  // rate, but no byte is ever pushed into a full buffer.
  // The bus is also ignored for one tick after the turnaround, since
  // the data stages still hold what stood on the released bus.
  assign link_take = (st_nxt == ST_IDLE) & (st_r == ST_IDLE) &
                     idle_old_r & buf_in_ready & ~nxt &
                     (d_s2_r != `UPI_IDLE_BYTE) & ~stp_s_r[1];

  // Port outputs, all registered and moved on the tick, except tx_ready, which drops the clock after
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r        <= ST_OFF;
      dir         <= 1'b0;
      nxt         <= 1'b0;
      data_out    <= `UPI_IDLE_BYTE;
      data_oe     <= 8'h00;
      tx_ready    <= 1'b0;
    end else if (!run) begin
      // all port drivers released while suspended
      st_r     <= ST_OFF;
      dir      <= 1'b0;
      nxt      <= 1'b0;
      data_oe  <= 8'h00;
      tx_ready <= 1'b0;
    end else if (tick_r) begin
      st_r       <= st_nxt;
      // direction high from turnaround through send
      dir        <= (st_nxt == ST_TAU) | (st_nxt == ST_SEND);
      // no drive in either turnaround cycle
      data_oe    <= (st_nxt == ST_SEND) ? 8'hff : 8'h00;
      // byte lanes map straight, bit 7 is MSB
      // in-band status bytes ride this same path
      data_out   <= tx_data;
      tx_ready   <= (st_nxt == ST_SEND) & tx_valid;
      // next is the registered acceptance decision
      nxt        <= link_take;
    end else begin
      // Taken pulse lasts one clock, not a whole tick period
      tx_ready    <= 1'b0;
    end
  end

  // accepted byte held, next one taken two ticks later at the earliest
  // The byte that a next pulse took is in the second data stage one
  // tick later; it is caught there and offered for one clock.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stp_seen_r  <= 1'b0;
      idle_old_r  <= 1'b0;
      last_byte_r <= 8'h00;
      byte_hold_r <= 1'b0;
    end else if (!run) begin
      idle_old_r  <= 1'b0;
      byte_hold_r <= 1'b0;
    end else if (tick_r) begin
      stp_seen_r  <= stp_s_r[1];
      idle_old_r  <= (st_r == ST_IDLE);
      byte_hold_r <= nxt;
      last_byte_r <= d_s2_r;
    end else begin
      byte_hold_r <= 1'b0;
    end
  end

  // stop marks the previous byte as the last of the stream
  // a stop is taken as a single-cycle event on its rise
  // A stop held high longer still marks only one word, since the rise
  // is found against the level kept at the previous tick.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rx_data  <= 8'h00;
      rx_valid <= 1'b0;
      rx_last  <= 1'b0;
    end else if (!run) begin
      rx_valid <= 1'b0;
      rx_last  <= 1'b0;
    end else if (buf_pop) begin
      rx_valid <= buf_out_valid;
      rx_data  <= buf_out_data;
      rx_last  <= tick_r & stp_s_r[1] & ~stp_seen_r;
    end
  end

  // Receive buffer; its ready throttles next, so no byte is lost
  upi_buf2 u_buf (
    .clock     (clock),
    .nrst      (nrst),
    .in_data   (last_byte_r),
    .in_valid  (byte_hold_r),
    .in_ready  (buf_in_ready),
    .out_data  (buf_out_data),
    .out_valid (buf_out_valid),
    .out_ready (buf_pop)
  );

  // bus-power pin senses level and drives pulses
  // Sensing stays live while pulsing, so the level reported back
  // includes the charge that the pulse itself puts on the line.
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      vbus_out   <= 1'b0;
      vbus_oe    <= 1'b0;
      vbus_valid <= 1'b0;
    end else begin
      vbus_out   <= run & vbus_pulse_req;
      vbus_oe    <= run & vbus_pulse_req;
      vbus_valid <= run & vb_s_r[1];
    end
  end
endmodule
`default_nettype wire

/* File: inc/ulpi_pin_regs.vh */
// Constants for the transceiver-side link port block
`ifndef ULPI_PIN_REGS_VH
`define ULPI_PIN_REGS_VH
`define UPI_SYS_CLK_MHZ       100
`define UPI_IFCLK_MHZ         60
`define UPI_IFCLK_DIV         2
`define UPI_REF_SEL_13M       2'b00
`define UPI_REF_SEL_19M2      2'b01
`define UPI_REF_SEL_26M       2'b10
`define UPI_REF_SEL_24M       2'b11
`define UPI_REF_KHZ_13M       15'h32c8
`define UPI_REF_KHZ_19M2      15'h4b00
`define UPI_REF_KHZ_26M       15'h6590
`define UPI_REF_KHZ_24M       15'h5dc0
`define UPI_DATA_W            8
`define UPI_BUF_DEPTH         2
`define UPI_IDLE_BYTE         8'h00
`endif

/* File: rtl/upi_buf2.v */
// Two-entry valid/ready buffer for received bytes
`timescale 1ns/1ns
`default_nettype none
module upi_buf2 (
  input  wire       clock,
  input  wire       nrst,
  input  wire [7:0] in_data,
  input  wire       in_valid,
  output wire       in_ready,
  output wire [7:0] out_data,
  output wire       out_valid,
  input  wire       out_ready
);
  reg [7:0] mem_r [0:1];
  reg       wp_r;
  reg       rp_r;
  reg [1:0] cnt_r;
  wire      push;
  wire      pop;

  // Honest full and empty from the occupancy count
  assign in_ready  = (cnt_r != 2'h2);
  assign out_valid = (cnt_r != 2'h0);
  assign out_data  = mem_r[rp_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointers and count
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wp_r     <= 1'b0;
      rp_r     <= 1'b0;
      cnt_r    <= 2'h0;
      mem_r[0] <= 8'h00;
      mem_r[1] <= 8'h00;
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r        <= ~wp_r;
      end
      if (pop)
        rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
`default_nettype wire

/* File: dv/upi_port_assertions.sv */
// Pin-level checks for the link port block
`timescale 1ns/1ns
`default_nettype none
module upi_port_assertions (
  input wire logic       clock,
  input wire logic       nrst,
  input wire logic       chip_reset_n,
  input wire logic       interface_clock_out,
  input wire logic [7:0] data_oe,
  input wire logic       dir,
  input wire logic       nxt,
  input wire logic       tx_ready,
  input wire logic       vbus_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_ifclk_half:
    assert property ($rose(interface_clock_out) |=> !interface_clock_out)
    else $error("interface clock not halved");
  a_dir_hold:
    assert property ($rose(dir) |=> dir)
    else $error("dir shorter than a tick");
  a_turn_rise:
    assert property ($rose(dir) |-> data_oe == 8'h00 ##1 data_oe == 8'h00)
    else $error("bus driven in turnaround");
  a_turn_fall:
    assert property ($fell(dir) |-> data_oe == 8'h00)
    else $error("dir fell while driving");
  a_oe_owner:
    assert property (data_oe != 8'h00 |-> dir)
    else $error("bus driven without dir");
  a_nxt_inbound:
    assert property (nxt |-> !dir)
    else $error("nxt while sending");
  a_ready_send:
    assert property (tx_ready |-> dir && data_oe == 8'hff)
    else $error("byte taken off the bus");
  a_suspend_quiet:
    assert property (!chip_reset_n [*4] |-> !dir && !nxt && !vbus_oe
      && data_oe == 8'h00)
    else $error("pins driven in suspend");
endmodule
`default_nettype wire

/* File: dv/upi_link_model.sv */
// Behavioural link controller on the far side of the bus
`timescale 1ns/1ns
`default_nettype none
module upi_link_model (
  input wire logic       ck,
  input wire logic       dir,
  input wire logic       nxt,
  input wire logic [7:0] bus,
  output logic     [7:0] drv,
  output logic           stp
);
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  logic       act = 1'b0;
  logic       dir_q = 1'b0;
  initial drv = 8'h00;
  initial stp = 1'b0;
  // Acts just after the interface clock rise, like a real link
  always @(posedge ck) begin
    #1;
    stp = 1'b0;
    // bytes pass whole, status collected after turnaround
    if (dir && dir_q) rxq.push_back(bus);
    // next byte after acceptance, one-cycle stop after the last
    if (act && nxt) begin
      void'(txq.pop_front());
      act = txq.size() != 0;
      stp = !act;
    end else if (!act && txq.size() != 0 && !dir && !dir_q) begin
      act = 1'b1;
    end
    // released bus toggles so stale data never passes
    drv = act ? txq[0] : (dir || dir_q) ? ~drv : 8'h00;
    dir_q = dir;
  end
endmodule
`default_nettype wire

/* File: dv/ulpi_phy_pin_interface_bench.sv */
// Self-checking bench for the link port block
`timescale 1ns/1ns
`default_nettype none
module ulpi_phy_pin_interface_bench;
  logic        clock = 1'b0, nrst = 1'b0, chip_reset_n = 1'b1;
  logic        reference_clock_in = 1'b0, tx_valid = 1'b0, rx_ready = 1'b1;
  logic        vbus_pulse_req = 1'b0, vbus_in = 1'b0;
  logic [1:0]  ref_freq_select = 2'b00;
  logic [7:0]  tx_data = 8'h00;
  wire logic   interface_clock_out, dir, nxt, stp, tx_ready, rx_valid;
  wire logic   rx_last, vbus_out, vbus_oe, vbus_valid, ref_ok;
  wire logic [7:0]  data_in, data_out, data_oe, rx_data, drv;
  wire logic [14:0] ref_khz;
  int          err_total = 0, samples_checked = 0;
  upi_port i_dut (.clock, .nrst, .chip_reset_n, .ref_freq_select,
    .reference_clock_in, .interface_clock_out, .data_in, .data_out, .data_oe,
    .dir, .nxt, .stp, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid,
    .rx_ready, .rx_last, .vbus_pulse_req, .vbus_in, .vbus_out, .vbus_oe,
    .vbus_valid, .ref_ok, .ref_khz);
  upi_link_model i_link (.ck(interface_clock_out), .dir, .nxt,
    .bus(data_in), .drv, .stp);
  // Wire level: each bit comes from whoever enables it
  assign data_in = (data_oe & data_out) | (~data_oe & drv);
  // System clock, and a reference out of phase with it
  initial forever #5 clock = ~clock;
  initial forever begin
    #62 reference_clock_in = 1'b1;
    #63 reference_clock_in = 1'b0;
  end
  task automatic chk(string what, logic [14:0] exp, logic [14:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic t_straps;
    logic [14:0] khz[4] = '{15'h32c8, 15'h4b00, 15'h6590, 15'h5dc0};
    for (int s = 0; s < 4; s++) begin
      nrst = 1'b0;
      ref_freq_select = s[1:0];
      tick(2);
      nrst = 1'b1;
      for (int i = 0; i < 200 && ref_ok !== 1'b1; i++) tick(1);
      chk("ref_khz", khz[s], ref_khz);
      chk("ref_ok", 15'h1, {14'h0000, ref_ok});
    end
  endtask
  task automatic t_send;
    logic [7:0] b[3] = '{8'ha5, 8'h3c, 8'h81};
    int k = 0;
    tx_data = b[0];
    tx_valid = 1'b1;
    for (int i = 0; i < 100 && k < 3; i++) begin
      @(posedge clock);
      if (tx_ready === 1'b1) k++;
      #1 tx_valid = k < 3;
      if (k < 3) tx_data = b[k];
    end
    tick(40);
    for (int i = 0; i < 3; i++) chk("sent", 15'(b[i]), 15'(i_link.rxq[i]));
  endtask
  task automatic t_recv;
    logic [7:0] b[4] = '{8'h11, 8'h22, 8'h33, 8'h44};
    int k = 0;
    logic last = 1'b0;
    rx_ready = 1'b0;
    foreach (b[i]) i_link.txq.push_back(b[i]);
    tick(80);
    chk("stalled", 15'h1, 15'(i_link.txq.size() != 0));
    rx_ready = 1'b1;
    for (int i = 0; i < 400 && i < 60 + 400 * (k < 4); i++) begin
      @(posedge clock);
      last = last | rx_last;
      if (rx_valid === 1'b1 && k < 4) begin
        chk("rx_data", 15'(b[k]), 15'(rx_data));
        k++;
      end
      #1;
    end
    chk("rx count", 15'h4, 15'(k));
    chk("rx_last", 15'h1, 15'(last));
  endtask
  task automatic t_suspend;
    chip_reset_n = 1'b0;
    tx_valid = 1'b1;
    vbus_pulse_req = 1'b1;
    tick(10);
    chk("suspended", 15'h0, {4'h0, data_oe, dir, nxt, vbus_oe});
    tx_valid = 1'b0;
    chip_reset_n = 1'b1;
    vbus_in = 1'b1;
    tick(16);
    chk("vbus", 15'h7, {12'h000, vbus_out, vbus_oe, vbus_valid});
    vbus_pulse_req = 1'b0;
    vbus_in = 1'b0;
    tick(16);
    chk("vbus off", 15'h0, {12'h000, vbus_out, vbus_oe, vbus_valid});
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    t_straps();
    t_send();
    t_recv();
    t_suspend();
    give_verdict();
  end
  // Whole run needs a few hundred cycles; this cuts a hang short
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule
bind upi_port upi_port_assertions u_chk (.clock, .nrst, .chip_reset_n,
  .interface_clock_out, .data_oe, .dir, .nxt, .tx_ready, .vbus_oe);
`default_nettype wire
